// *** hdl/tsl_lamp_ctrl.sv ***
// turn-signal lamp controller with tick timer, subdivider and axi4-lite registers
//
// Contract
// - time base is a 16-bit mode-1 timer of cascaded low and high bytes
// - low byte counts each machine cycle; its overflow bumps the high byte
// - high-byte overflow requests tick; delivered only with both enables and run set
// - high byte preset minus sixteen, low zero, gives a 4.096 ms tick
// - each tick reloads the high byte preset on the same edge as the subdivider moves
// - tick service entered at the timer service vector location
// - subdivider starts at 244, decrements per tick, reloads 244 at zero
// - subdivider bit 0 toggles per tick as fast modulation
// - dim term is parking input AND fast modulation
// - left dash is (left turn OR hazard) AND slow blink bit
// - left front is left dash OR dim term
// - left rear is (brake AND NOT left turn) OR left dash OR dim
// - right lamps computed alike using the right-turn input
// - inputs sampled and lamps recomputed on every tick
// - optional dim duty cycles other than half from low subdivider bits
// - control bits 10..8 select one of seven duty cycles, compared against subdivider bits 2..0
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module tsl_lamp_ctrl
  import tsl_pkg::*;
#(
  parameter int MACHINE_NS = MACHINE_CYCLE_NS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic brakeIn,
  input wire logic hazardSwitchIn,
  input wire logic parkIn,
  input wire logic leftTurnIn,
  input wire logic rightTurnIn,
  output logic leftFrontLamp,
  output logic rightFrontLamp,
  output logic leftDashLamp,
  output logic rightDashLamp,
  output logic leftRearLamp,
  output logic rightRearLamp,
  output logic irq,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  // machine cycles in clocks, never below one
  localparam int MC_RAW = MACHINE_NS / CLK_PERIOD_NS;
  localparam int MC_CYCLES = (MC_RAW < 1) ? 1 : MC_RAW;
  localparam logic [15:0] MC_LAST = 16'(MC_CYCLES - 1);

  logic [15:0] mcCount_q;
  logic machineCycleEn;
  logic [4:0] syncA_q, syncB_q;
  logic [7:0] tickTimerLowByte_q, tickTimerHighByte_q, subdiv_q;
  logic overflowPending_q, tickD_q;
  logic [10:0] ctrl_q;
  logic [EVT_W-1:0] status_q, mask_q;
  logic [5:0] lamps_q;
  logic awHeld_q, wHeld_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0] awAddr_q;
  logic [31:0] wData_q, rdata_q;
  logic [3:0] wStrb_q;
  logic [1:0] bresp_q, rresp_q;

  // control fields
  wire tickTimerRun = ctrl_q[CTRL_RUN_BIT];
  wire tickInterruptEnable = ctrl_q[CTRL_TIE_BIT];
  wire globalInterruptEnable = ctrl_q[CTRL_GIE_BIT];
  wire [1:0] timerModeSetting = ctrl_q[CTRL_MODE_LSB +: 2];
  wire [2:0] dimDutySel = ctrl_q[CTRL_DUTY_LSB +: 3];

  // synchronised switches, active high
  wire brakeSync = syncB_q[0];
  wire hazardSwitchSync = syncB_q[1];
  wire parkSync = syncB_q[2];
  wire leftTurnSync = syncB_q[3];
  wire rightTurnSync = syncB_q[4];

  // timer decode
  wire timerRunning = tickTimerRun && (timerModeSetting == TIMER_MODE_16BIT);
  wire lowWrap = machineCycleEn && timerRunning && (tickTimerLowByte_q == BYTE_MAX);
  wire highWrap = lowWrap && (tickTimerHighByte_q == BYTE_MAX);
  wire tickPulse = overflowPending_q && tickInterruptEnable
    && globalInterruptEnable && tickTimerRun;
  wire subdivAtOne = (subdiv_q == BYTE_ONE);
  wire [7:0] subdivNext = subdivAtOne ? SUBDIV_RELOAD : subdiv_q - BYTE_ONE;

  // lamp equations from current subdivider
  wire fastModulationBit = subdiv_q[FAST_MOD_BIT];
  wire slowBlinkBit = subdiv_q[SLOW_BLINK_BIT];
  wire [3:0] dutyThreshold = DUTY_STEPS - {1'b0, dimDutySel};
  wire dutyOn = ({1'b0, subdiv_q[2:0]} >= dutyThreshold);
  wire dimMod = (dimDutySel == 3'h0) ? fastModulationBit : dutyOn;
  wire parkingDimTerm = parkSync && dimMod;
  wire leftSideFunction = (leftTurnSync || hazardSwitchSync) && slowBlinkBit;
  wire rightSideFunction = (rightTurnSync || hazardSwitchSync) && slowBlinkBit;
  wire leftFrontD = leftSideFunction || parkingDimTerm;
  wire rightFrontD = rightSideFunction || parkingDimTerm;
  wire leftRearD = (brakeSync && !leftTurnSync) || leftSideFunction
    || parkingDimTerm;
  wire rightRearD = (brakeSync && !rightTurnSync) || rightSideFunction
    || parkingDimTerm;
  wire leftDashD = leftSideFunction;
  wire rightDashD = rightSideFunction;
  wire [5:0] lampsD = {rightRearD, leftRearD, rightDashD, leftDashD, rightFrontD, leftFrontD};

  // bus decode
  wire wrFire = awHeld_q && wHeld_q && !bvalid_q;
  wire arFire = s_axi_arvalid && s_axi_arready;
  wire wrCtrl = wrFire && (awAddr_q == OFS_CTRL);
  wire wrMask = wrFire && (awAddr_q == OFS_MASK);
  wire wrHit = wrCtrl || wrMask || (awAddr_q == OFS_STATUS)
    || (awAddr_q == OFS_SUBDIV) || (awAddr_q == OFS_TIMER)
    || (awAddr_q == OFS_LAMPS) || (awAddr_q == OFS_VECTOR);
  wire rdStatus = arFire && (s_axi_araddr == OFS_STATUS);
  wire [EVT_W-1:0] eventSet = {tickPulse && subdivAtOne, tickPulse};
  wire [31:0] ctrlWMask = {21'h0, CTRL_WMASK}
    & {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
  wire [31:0] ctrlNew = ({21'h0, ctrl_q} & ~ctrlWMask) | (wData_q & ctrlWMask);
  logic [31:0] rdMux;
  logic rdHit;

  // read data selection
  always_comb begin
    rdHit = 1'b1;
    rdMux = 32'h0;
    case (s_axi_araddr)
      OFS_CTRL: rdMux = {21'h0, ctrl_q};
      OFS_STATUS: rdMux = {30'h0, status_q};
      OFS_MASK: rdMux = {30'h0, mask_q};
      OFS_SUBDIV: rdMux = {24'h0, subdiv_q};
      OFS_TIMER: rdMux = {16'h0, tickTimerHighByte_q, tickTimerLowByte_q};
      OFS_LAMPS: rdMux = {19'h0, syncB_q, 2'h0, lamps_q};
      OFS_VECTOR: rdMux = {16'h0, TICK_VECTOR};
      default: rdHit = 1'b0;
    endcase
  end

  // machine-cycle enable divider
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mcCount_q <= 16'h0;
    end else if (mcCount_q == MC_LAST) begin
      mcCount_q <= 16'h0;
    end else begin
      mcCount_q <= mcCount_q + 16'h1;
    end
  end
  assign machineCycleEn = (mcCount_q == MC_LAST);

  // two-flop switch synchroniser
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      syncA_q <= 5'h0;
      syncB_q <= 5'h0;
    end else begin
      syncA_q <= {rightTurnIn, leftTurnIn, parkIn, hazardSwitchIn, brakeIn};
      syncB_q <= syncA_q;
    end
  end

  // low timer byte
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tickTimerLowByte_q <= LOW_BYTE_INIT;
    end else if (machineCycleEn && timerRunning) begin
      tickTimerLowByte_q <= tickTimerLowByte_q + BYTE_ONE;
    end
  end

  // high timer byte, preset reload wins on a tick
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tickTimerHighByte_q <= TICK_PRESET;
    end else if (tickPulse) begin
      tickTimerHighByte_q <= TICK_PRESET;
    end else if (lowWrap) begin
      tickTimerHighByte_q <= tickTimerHighByte_q + BYTE_ONE;
    end
  end

  // overflow request, new overflow wins over delivery
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      overflowPending_q <= 1'b0;
    end else if (highWrap) begin
      overflowPending_q <= 1'b1;
    end else if (tickPulse) begin
      overflowPending_q <= 1'b0;
    end
  end

  // subdivider and delayed lamp load
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      subdiv_q <= SUBDIV_RELOAD;
      tickD_q <= 1'b0;
    end else begin
      tickD_q <= tickPulse;
      if (tickPulse) begin
        subdiv_q <= subdivNext;
      end
    end
  end

  // lamp outputs, all six in one edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lamps_q <= 6'h0;
    end else if (tickD_q) begin
      lamps_q <= lampsD;
    end
  end
  assign leftFrontLamp = lamps_q[0];
  assign rightFrontLamp = lamps_q[1];
  assign leftDashLamp = lamps_q[2];
  assign rightDashLamp = lamps_q[3];
  assign leftRearLamp = lamps_q[4];
  assign rightRearLamp = lamps_q[5];

  // control and mask registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
      mask_q <= EVT_RESET;
    end else begin
      if (wrCtrl) begin
        ctrl_q <= ctrlNew[10:0];
      end
      if (wrMask && wStrb_q[0]) begin
        mask_q <= wData_q[EVT_W-1:0];
      end
    end
  end

  // sticky status, set beats read-clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status_q <= EVT_RESET;
    end else begin
      status_q <= (rdStatus ? EVT_RESET : status_q) | eventSet;
    end
  end
  assign irq = |(status_q & mask_q);

  // write channel capture and response
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= '0;
      wData_q <= 32'h0;
      wStrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (wrFire) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !awHeld_q && !bvalid_q;
  assign s_axi_wready = !wHeld_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // read channel
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= RESP_OKAY;
    end else if (arFire) begin
      rvalid_q <= 1'b1;
      rdata_q <= rdMux;
      rresp_q <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  logic seenLoad_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      seenLoad_q <= 1'b0;
    end else if (tickD_q) begin
      seenLoad_q <= 1'b1;
    end
  end

  sequence seqTick;
    tickPulse;
  endsequence
  sequence seqLoadNext;
    ##1 tickD_q ##1 lamps_q == $past(lampsD);
  endsequence

  chk_tick_gating: assert property (seqTick |-> tickInterruptEnable
    && globalInterruptEnable && tickTimerRun) else $error("tick without enables");
  chk_overflow_request: assert property (highWrap |=> overflowPending_q)
    else $error("high overflow lost");
  chk_low_advance: assert property (machineCycleEn && timerRunning |=>
    tickTimerLowByte_q == $past(tickTimerLowByte_q) + BYTE_ONE)
    else $error("low byte did not advance");
  chk_high_reload: assert property (seqTick |=> tickTimerHighByte_q == TICK_PRESET)
    else $error("high byte not preset");
  chk_subdiv_step: assert property (seqTick |=> subdiv_q ==
    (($past(subdiv_q) == BYTE_ONE) ? SUBDIV_RELOAD : $past(subdiv_q) - BYTE_ONE))
    else $error("subdivider step wrong");
  chk_fast_toggle: assert property ((seqTick and !subdivAtOne) |=>
    subdiv_q[FAST_MOD_BIT] != $past(subdiv_q[FAST_MOD_BIT]))
    else $error("fast bit did not toggle");
  chk_lamp_load: assert property (seqTick |-> seqLoadNext)
    else $error("lamp load missing");
  chk_lamps_together: assert property (lamps_q != $past(lamps_q) |-> $past(tickD_q))
    else $error("lamps changed off tick");
  chk_left_dash_eq: assert property (tickD_q |=> leftDashLamp ==
    (($past(leftTurnSync) || $past(hazardSwitchSync)) && $past(slowBlinkBit)))
    else $error("left dash wrong");
  chk_left_front_eq: assert property (tickD_q |=> leftFrontLamp ==
    ($past(leftSideFunction) || ($past(parkSync) && $past(dimMod))))
    else $error("left front wrong");
  chk_left_rear_eq: assert property (tickD_q |=> leftRearLamp ==
    (($past(brakeSync) && !$past(leftTurnSync)) || $past(leftSideFunction)
    || $past(parkingDimTerm))) else $error("left rear wrong");
  chk_right_rear_eq: assert property (tickD_q |=> rightRearLamp ==
    (($past(brakeSync) && !$past(rightTurnSync)) || $past(rightSideFunction)
    || $past(parkingDimTerm))) else $error("right rear wrong");
  chk_lamps_reset_off: assert property (!seenLoad_q |-> lamps_q == 6'h0)
    else $error("lamp lit before first tick");
  // a held-off overflow waits for the enables instead of being dropped
  chk_tick_deferred: assert property (overflowPending_q && !tickPulse |=> overflowPending_q)
    else $error("pending overflow lost");
  chk_status_sticky: assert property (seqTick |=> status_q[EVT_TICK_BIT])
    else $error("tick event not latched");
endmodule

// *** inc/tsl_pkg.sv ***
// constants for the turn-signal lamp controller
package tsl_pkg;
  // clock and machine-cycle timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int MACHINE_CYCLE_NS = 1000;
  // tick timer
  localparam logic [1:0] TIMER_MODE_16BIT = 2'h1;
  localparam logic [7:0] TICK_PRESET = 8'hf0; // minus sixteen
  localparam logic [7:0] LOW_BYTE_INIT = 8'h00;
  localparam logic [7:0] BYTE_MAX = 8'hff;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [15:0] TICK_VECTOR = 16'h000b;
  // subdivider
  localparam logic [7:0] SUBDIV_RELOAD = 8'hf4; // 244 ticks
  localparam int SLOW_BLINK_BIT = 7;
  localparam int FAST_MOD_BIT = 0;
  localparam logic [3:0] DUTY_STEPS = 4'h8;
  // register offsets (byte addresses)
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_SUBDIV = 8'h0c;
  localparam logic [7:0] OFS_TIMER = 8'h10;
  localparam logic [7:0] OFS_LAMPS = 8'h14;
  localparam logic [7:0] OFS_VECTOR = 8'h18;
  // control register fields
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_TIE_BIT = 1;
  localparam int CTRL_GIE_BIT = 2;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CTRL_DUTY_LSB = 8;
  localparam logic [10:0] CTRL_RESET = 11'h000;
  localparam logic [10:0] CTRL_WMASK = 11'h737;
  // status and mask fields
  localparam int EVT_W = 2;
  localparam int EVT_TICK_BIT = 0;
  localparam int EVT_BLINK_BIT = 1;
  localparam logic [1:0] EVT_RESET = 2'h0;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** tb/tb_tsl_lamp_ctrl.sv ***
// self-checking bench for the turn-signal lamp controller
`timescale 1ns/1ps
module tb_tsl_lamp_ctrl
  import tsl_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] swCmd = 5'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  wire logic awready, wready, bvalid, arready, rvalid, irq;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic brakeIn, hazardSwitchIn, parkIn, leftTurnIn, rightTurnIn;
  wire logic lf, rf, ld, rd, lr, rr;
  wire logic [5:0] lamps = {rr, lr, rd, ld, rf, lf};
  int failCount = 0, testsRun = 0, cyc = 0;
  logic [31:0] rdVal;
  logic [1:0] respVal;

  tsl_switch_model u_sw (.swCmd(swCmd), .brakeIn(brakeIn), .hazardSwitchIn(hazardSwitchIn),
    .parkIn(parkIn), .leftTurnIn(leftTurnIn), .rightTurnIn(rightTurnIn));

  // one clock per machine cycle keeps the tick at 4096 clocks
  tsl_lamp_ctrl #(.MACHINE_NS(25)) u_dut (.ref_clk(ref_clk), .rst(rst), .brakeIn(brakeIn),
    .hazardSwitchIn(hazardSwitchIn), .parkIn(parkIn), .leftTurnIn(leftTurnIn),
    .rightTurnIn(rightTurnIn), .leftFrontLamp(lf), .rightFrontLamp(rf), .leftDashLamp(ld),
    .rightDashLamp(rd), .leftRearLamp(lr), .rightRearLamp(rr), .irq(irq),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));

  // 40 MHz clock
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    testsRun++;
    if (seen !== exp) begin
      failCount++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic giveVerdict();
    $display("checks %0d, mismatches %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // cycle count and hang limit
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      failCount++;
      giveVerdict();
    end
  end

  // waits as long as the slave needs; only the cycle ceiling ends a hang
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    bready <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    respVal = bresp;
    bready <= 1'b0;
    check(32'(bvalid), 32'h1, "write answer");
  endtask

  task automatic axiRd(input logic [7:0] a);
    @(posedge ref_clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rdVal = rdata;
    respVal = rresp;
    rready <= 1'b0;
    check(32'(rvalid), 32'h1, "read answer");
  endtask

  task automatic waitIrq();
    int n;
    for (n = 0; n < 5000; n++) begin
      @(posedge ref_clk);
      if (irq === 1'b1) break;
    end
    check(32'(n < 5000), 32'h1, "tick interrupt");
  endtask

  function automatic logic [5:0] expLamps(logic [4:0] sw, logic [7:0] s, logic [2:0] k);
    logic fast, parking_dim_term, ldx, rdx;
    fast = (k == 3'h0) ? s[0] : (({1'b0, s[2:0]} + {1'b0, k}) >= 4'h8);
    parking_dim_term = sw[2] & fast;
    ldx = (sw[3] | sw[1]) & s[7];
    rdx = (sw[4] | sw[1]) & s[7];
    return {(sw[0] & ~sw[4]) | rdx | parking_dim_term, (sw[0] & ~sw[3]) | ldx | parking_dim_term, rdx, ldx,
            rdx | parking_dim_term, ldx | parking_dim_term};
  endfunction

  task automatic testReset();
    check(32'(lamps), 32'h0, "lamps after reset");
    check(32'(irq), 32'h0, "irq after reset");
    axiRd(OFS_CTRL);
    check(rdVal, 32'h0, "ctrl reset");
    axiRd(OFS_SUBDIV);
    check(rdVal, 32'd244, "subdivider reset");
    axiRd(OFS_TIMER);
    check(rdVal, 32'h0000f000, "timer preset");
    axiRd(OFS_VECTOR);
    check(rdVal, 32'h0000000b, "service vector");
    axiRd(8'h40);
    check(32'(respVal), 32'(RESP_SLVERR), "unmapped read");
    check(rdVal, 32'h0, "unmapped data");
    axiWr(8'h40, 32'hffff);
    check(32'(respVal), 32'(RESP_SLVERR), "unmapped write");
    axiWr(OFS_VECTOR, 32'hffff);
    check(32'(respVal), 32'(RESP_OKAY), "read-only write");
    axiRd(OFS_VECTOR);
    check(rdVal, 32'h0000000b, "vector unchanged");
    axiWr(OFS_CTRL, 32'h1);
    repeat (8) @(posedge ref_clk);
    axiRd(OFS_TIMER);
    check(rdVal, 32'h0000f000, "timer idle outside mode 1");
    $display("reset test done");
  endtask

  task automatic testDefer();
    axiWr(OFS_MASK, 32'h0);
    axiWr(OFS_CTRL, 32'h11);
    repeat (4400) @(posedge ref_clk);
    axiRd(OFS_SUBDIV);
    check(rdVal, 32'd244, "tick held without enables");
    check(32'(lamps), 32'h0, "lamps before first tick");
    axiWr(OFS_CTRL, 32'h17);
    repeat (4) @(posedge ref_clk);
    check(32'(irq), 32'h0, "masked irq");
    axiRd(OFS_SUBDIV);
    check(rdVal, 32'd243, "pending tick delivered");
    axiWr(OFS_MASK, 32'h1);
    @(posedge ref_clk);
    check(32'(irq), 32'h1, "unmasked irq");
    axiRd(OFS_MASK);
    check(rdVal, 32'h1, "mask readback");
    axiRd(OFS_STATUS);
    check(rdVal, 32'h1, "tick status");
    @(posedge ref_clk);
    check(32'(irq), 32'h0, "irq after clear");
    $display("deferred tick test done");
  endtask

  task automatic testPeriod();
    int t0;
    waitIrq();
    t0 = cyc;
    axiRd(OFS_STATUS);
    waitIrq();
    check(32'((cyc - t0) inside {4096, 4097}), 32'h1, "tick spacing");
    axiRd(OFS_STATUS);
    $display("tick period test done");
  endtask

  task automatic testLamps();
    logic [4:0] sw;
    logic [2:0] k;
    logic [5:0] ex;
    logic [7:0] prevS;
    for (int i = 0; i < 14; i++) begin
      sw = 5'((i * 13) % 32);
      k = 3'(i % 8);
      swCmd <= sw;
      axiWr(OFS_CTRL, 32'h17 | (32'(k) << 8));
      waitIrq();
      axiRd(OFS_STATUS);
      check(rdVal, 32'h1, "tick status");
      repeat (2) @(posedge ref_clk);
      axiRd(OFS_SUBDIV);
      if (i > 0) check(rdVal, 32'(prevS - 8'h01), "subdivider step");
      prevS = rdVal[7:0];
      ex = expLamps(sw, prevS, k);
      check(32'(lamps), 32'(ex), "lamp ports");
      axiRd(OFS_LAMPS);
      check(rdVal, {19'h0, sw, 2'b00, ex}, "lamp register");
    end
    $display("lamp logic test done");
  endtask

  // main sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    testReset();
    testDefer();
    testPeriod();
    testLamps();
    giveVerdict();
  end
endmodule

// *** tb/tsl_switch_model.sv ***
// switch bank model that feeds the lamp controller
`timescale 1ns/1ps
module tsl_switch_model (
  input wire logic [4:0] swCmd,
  output logic brakeIn,
  output logic hazardSwitchIn,
  output logic parkIn,
  output logic leftTurnIn,
  output logic rightTurnIn
);
  // a selected switch pulls its line high
  assign brakeIn = swCmd[0];
  assign hazardSwitchIn = swCmd[1];
  assign parkIn = swCmd[2];
  assign leftTurnIn = swCmd[3];
  assign rightTurnIn = swCmd[4];
endmodule
